/* File: cfs_cpu_regs.sv */
// cpu state registers: program counter, condition flags, stack pointer and the
// interrupt context save and restore sequencer.
// assumes the instruction sequencer issues one op per cycle only while busy is low,
// and the stack ram answers a read combinationally on stk_rdata.
// a stack walk holds busy high until its whole frame has moved;
// the second index register never rides on the stack.
module cfs_cpu_regs (
   input wire logic mclk,
   input wire logic rst_n,
   input wire cfs_pkg::cfs_op_t op,
   input wire cfs_pkg::cfs_fl_t fl_kind,
   input wire logic [7:0] alu_result,
   input wire logic alu_carry,
   input wire logic alu_half,
   input wire logic [7:0] push_data,
   input wire logic [7:0] ld_s_data,
   input wire logic jump_en,
   input wire logic [15:0] jump_addr,
   input wire logic pc_inc,
   input wire logic [15:0] int_vector,
   input wire logic irq_req,
   input wire logic [7:0] reg_a,
   input wire logic [7:0] reg_x,
   input wire logic [7:0] stk_rdata,
   output logic [15:0] program_counter,
   output logic [7:0] next_addr_low_byte,
   output logic [7:0] next_addr_high_byte,
   output logic [7:0] condition_flags,
   output logic [15:0] stack_pointer,
   output logic busy,
   output logic irq_pending,
   output logic irq_ack,
   output logic [7:0] pop_data,
   output logic pop_valid,
   output logic [7:0] ctx_a,
   output logic [7:0] ctx_x,
   output logic ctx_valid,
   output logic [15:0] stk_addr,
   output logic stk_we,
   output logic [7:0] stk_wdata
);
   import cfs_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_INT, ST_HRETURN, ST_CALL, ST_RET
   } cfs_state_t;

   typedef struct packed {
      cfs_state_t st;
      logic [2:0] step;
      logic [15:0] pc;
      logic [15:0] tgt;
      logic [7:0] cc;
      logic pend;
      logic ack;
      logic [7:0] pop_byte;
      logic pop_valid;
      logic [7:0] a;
      logic [7:0] x;
      logic ctx_valid;
   } cfs_regs_t;

   cfs_regs_t s;
   cfs_regs_t next_s;

   cfs_stk_if stk ();

   logic [7:0] flag_cc;
   logic push_c;
   logic pop_c;
   logic rsp_c;
   logic lds_c;
   logic [7:0] wdata_c;
   logic walk_last;

   // context byte for a push-order index; the second index register has no slot
   function automatic logic [7:0] ctx_byte(input logic [2:0] idx, input logic [15:0] pc,
                                           input logic [7:0] x, input logic [7:0] a,
                                           input logic [7:0] cc);
      logic [7:0] b;
      b = 8'h00;
      case (idx)
         CTX_ADDR_LO: b = pc[7:0];
         CTX_ADDR_HI: b = pc[15:8];
         CTX_X: b = x;
         CTX_A: b = a;
         CTX_CC: b = cc;
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   // every whole-byte write to the flags goes through here so the top three bits stay set
   function automatic logic [7:0] cc_fix(input logic [7:0] v);
      return v | CC_FIXED_ONES;
   endfunction

   // last step of a stack walk: five bytes for an interrupt frame, two for a call
   function automatic logic [2:0] last_step(input cfs_state_t st);
      logic [2:0] n;
      n = CALL_BYTES;
      if (st == ST_INT || st == ST_HRETURN) begin
         n = INT_BYTES;
      end
      return n - 3'h1;
   endfunction

   cfs_flag_unit u_flags (
      .cc(s.cc),
      .kind(fl_kind),
      .result(alu_result),
      .carry(alu_carry),
      .half(alu_half),
      .next_cc(flag_cc)
   );

   cfs_stack_ptr u_stack (
      .mclk(mclk),
      .rst_n(rst_n),
      .stk(stk.core)
   );

   // stack controls go to the pointer unit the same cycle they are decided
   assign stk.push = push_c;
   assign stk.pop = pop_c;
   assign stk.rst_op = rsp_c;
   assign stk.ld_low = lds_c;
   assign stk.ld_data = ld_s_data;

   // one compare shared by the push and the pop walks
   assign walk_last = (s.step == last_step(s.st));

   // main sequencer: single-cycle ops in idle, multi-byte stack walks in the other states
   always_comb begin
      next_s = s;
      next_s.ack = 1'b0;
      next_s.pop_valid = 1'b0;
      next_s.ctx_valid = 1'b0;
      push_c = 1'b0;
      pop_c = 1'b0;
      rsp_c = 1'b0;
      lds_c = 1'b0;
      wdata_c = 8'h00;
      case (s.st)
         ST_IDLE: begin
            // a jump wins over the increment
            if (jump_en) begin
               next_s.pc = jump_addr;
            end else if (pc_inc) begin
               next_s.pc = s.pc + 16'h0001;
            end
            case (op)
               OP_FLAGS: begin
                  next_s.cc = cc_fix(flag_cc);
               end
               OP_SET_OVERFLOW: begin
                  // carry controls bypass the flag unit
                  next_s.cc[CC_C_BIT] = 1'b1;
               end
               OP_CLEAR_OVERFLOW: begin
                  next_s.cc[CC_C_BIT] = 1'b0;
               end
               OP_SIM: begin
                  next_s.cc[CC_I_BIT] = 1'b1;
               end
               OP_UNMASK: begin
                  next_s.cc[CC_I_BIT] = 1'b0;
               end
               OP_TRAP: begin
                  // the trap ignores the mask and does not consume a pending request
                  next_s.st = ST_INT;
                  next_s.step = 3'h0;
                  next_s.tgt = int_vector;
                  next_s.ack = 1'b1;
               end
               OP_HANDLER_RETURN: begin
                  // the mask is forced clear at the end of the walk
                  next_s.st = ST_HRETURN;
                  next_s.step = 3'h0;
               end
               OP_CALL: begin
                  // return address is the pc as it stands, the target waits in tgt
                  next_s.st = ST_CALL;
                  next_s.step = 3'h0;
                  next_s.tgt = jump_addr;
                  next_s.pc = s.pc;
               end
               OP_RET: begin
                  next_s.st = ST_RET;
                  next_s.step = 3'h0;
               end
               OP_STACK_RESET: begin
                  // the pointer unit reloads the stack top
                  rsp_c = 1'b1;
               end
               OP_LD_S: begin
                  // only the low byte moves; the high byte is fixed
                  lds_c = 1'b1;
               end
               OP_PUSH: begin
                  push_c = 1'b1;
                  wdata_c = push_data;
               end
               OP_PUSH_CC: begin
                  // flags go out as they stand, mask included
                  push_c = 1'b1;
                  wdata_c = s.cc;
               end
               OP_POP: begin
                  // the ram read is combinational, so the byte is taken this edge
                  pop_c = 1'b1;
                  next_s.pop_byte = stk_rdata;
                  next_s.pop_valid = 1'b1;
               end
               OP_POP_CC: begin
                  pop_c = 1'b1;
                  next_s.cc = cc_fix(stk_rdata);
               end
               default: begin
                  // between instructions a pending request is taken only while unmasked
                  if (s.pend && !s.cc[CC_I_BIT]) begin
                     next_s.st = ST_INT;
                     next_s.step = 3'h0;
                     next_s.tgt = int_vector;
                     next_s.pend = 1'b0;
                     next_s.ack = 1'b1;
                  end
               end
            endcase
         end
         ST_INT, ST_CALL: begin
            // push in context order, pc low first at the current pointer
            push_c = 1'b1;
            wdata_c = ctx_byte(s.step, s.pc, reg_x, reg_a, s.cc);
            if (walk_last) begin
               next_s.st = ST_IDLE;
               next_s.pc = s.tgt;
               // the mask is set only after the flags byte has gone out
               if (s.st == ST_INT) begin
                  next_s.cc[CC_I_BIT] = 1'b1;
               end
            end else begin
               next_s.step = s.step + 3'h1;
            end
         end
         ST_HRETURN, ST_RET: begin
            // reverse order: the last byte pushed comes back first
            // a call frame holds only the address bytes, so its index starts lower
            pop_c = 1'b1;
            case (last_step(s.st) - s.step)
               CTX_ADDR_LO: begin
                  next_s.pc[7:0] = stk_rdata;
               end
               CTX_ADDR_HI: begin
                  next_s.pc[15:8] = stk_rdata;
               end
               CTX_X: begin
                  next_s.x = stk_rdata;
               end
               CTX_A: begin
                  next_s.a = stk_rdata;
               end
               CTX_CC: begin
                  // top bits come back set whatever the stack held
                  next_s.cc = cc_fix(stk_rdata);
               end
               default: begin
                  next_s.x = s.x;
               end
            endcase
            if (walk_last) begin
               next_s.st = ST_IDLE;
               if (s.st == ST_HRETURN) begin
                  // restored flags are taken but the mask always leaves clear
                  next_s.cc[CC_I_BIT] = 1'b0;
                  next_s.ctx_valid = 1'b1;
               end
            end else begin
               next_s.step = s.step + 3'h1;
            end
         end
         default: begin
            next_s.st = ST_IDLE;
         end
      endcase
      // a request in the same cycle as a take is kept, set wins over clear
      if (irq_req) begin
         next_s.pend = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{
            st: ST_IDLE,
            step: 3'h0,
            pc: PC_RESET,
            tgt: PC_RESET,
            cc: CC_RESET,
            pend: 1'b0,
            ack: 1'b0,
            pop_byte: 8'h00,
            pop_valid: 1'b0,
            a: 8'h00,
            x: 8'h00,
            ctx_valid: 1'b0
         };
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state copy; stack port follows the pointer unit
   assign program_counter = s.pc;
   assign next_addr_low_byte = s.pc[7:0];
   assign next_addr_high_byte = s.pc[15:8];

   // architectural registers
   assign condition_flags = s.cc;
   assign stack_pointer = stk.sp;

   // status and one-cycle pulses, all from flops
   assign busy = (s.st != ST_IDLE);
   assign irq_pending = s.pend;
   assign irq_ack = s.ack;
   assign pop_data = s.pop_byte;
   assign pop_valid = s.pop_valid;
   assign ctx_a = s.a;
   assign ctx_x = s.x;
   assign ctx_valid = s.ctx_valid;

   // ram port stays combinational so a push lands on the deciding edge
   assign stk_addr = stk.addr;
   assign stk_we = push_c;
   assign stk_wdata = wdata_c;
endmodule

/* File: cfs_cpu_regs_chk.sv */
// checker for the cpu state registers, watching only the top module's ports.
// assumes one clock domain and the bind at the foot of this file.
module cfs_cpu_regs_chk (
   input wire logic mclk,
   input wire logic rst_n,
   input wire cfs_pkg::cfs_op_t op,
   input wire cfs_pkg::cfs_fl_t fl_kind,
   input wire logic [7:0] alu_result,
   input wire logic irq_req,
   input wire logic [7:0] stk_rdata,
   input wire logic [15:0] program_counter,
   input wire logic [7:0] next_addr_low_byte,
   input wire logic [7:0] next_addr_high_byte,
   input wire logic [7:0] condition_flags,
   input wire logic [15:0] stack_pointer,
   input wire logic busy,
   input wire logic irq_pending,
   input wire logic irq_ack,
   input wire logic [7:0] pop_data,
   input wire logic pop_valid,
   input wire logic [15:0] stk_addr,
   input wire logic stk_we
);
   import cfs_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // an op only counts when the sequencer is idle
   sequence s_idle(cfs_op_t o); !busy && op == o; endsequence
   sequence s_two_push; (busy && stk_we)[*2]; endsequence
   sequence s_ctx_save; (busy && stk_we)[*5]; endsequence
   property p_sp_high; stack_pointer[15:8] == 8'h01; endproperty
   property p_cc_top; condition_flags[7:5] == 3'h7; endproperty
   property p_pc_bytes; {next_addr_high_byte, next_addr_low_byte} == program_counter; endproperty
   property p_stack_reset; s_idle(OP_STACK_RESET) |=> stack_pointer == 16'h01FF; endproperty
   property p_push;
      s_idle(OP_PUSH) |-> (stk_we && stk_addr == stack_pointer)
         ##1 (stack_pointer[7:0] == $past(stack_pointer[7:0]) - 8'h01);
   endproperty
   property p_pop;
      s_idle(OP_POP) |-> (stk_addr == {8'h01, stack_pointer[7:0] + 8'h01})
         ##1 (pop_valid && pop_data == $past(stk_rdata));
   endproperty
   property p_call;
      s_idle(OP_CALL) |=> s_two_push
         ##1 (!busy && stack_pointer[7:0] == $past(stack_pointer[7:0], 3) - 8'h02);
   endproperty
   property p_entry; $rose(irq_ack) |-> s_ctx_save ##1 (!busy && condition_flags[3]); endproperty
   property p_set_carry; s_idle(OP_SET_OVERFLOW) |=> condition_flags[0]; endproperty
   property p_logic;
      (!busy && op == OP_FLAGS && fl_kind == FL_LOGIC) |=> (condition_flags[2] ==
         $past(alu_result[7]) && condition_flags[1] == ($past(alu_result) == 8'h00));
   endproperty
   property p_pend; irq_req |=> irq_pending; endproperty
   a_sp_high: assert property (p_sp_high) else $error("sp upper byte moved");
   a_cc_top: assert property (p_cc_top) else $error("flag top bits not one");
   a_pc_bytes: assert property (p_pc_bytes) else $error("pc bytes disagree");
   a_stack_reset: assert property (p_stack_reset) else $error("stack reset value wrong");
   a_push: assert property (p_push) else $error("push address or step wrong");
   a_pop: assert property (p_pop) else $error("pop address or data wrong");
   a_call: assert property (p_call) else $error("call stack use wrong");
   a_entry: assert property (p_entry) else $error("context save wrong");
   a_set_carry: assert property (p_set_carry) else $error("set carry failed");
   a_logic: assert property (p_logic) else $error("n or z flag wrong");
   a_pend: assert property (p_pend) else $error("request not held");
endmodule

bind cfs_cpu_regs cfs_cpu_regs_chk u_chk (.mclk(mclk), .rst_n(rst_n), .op(op),
   .fl_kind(fl_kind), .alu_result(alu_result), .irq_req(irq_req), .stk_rdata(stk_rdata),
   .program_counter(program_counter), .next_addr_low_byte(next_addr_low_byte),
   .next_addr_high_byte(next_addr_high_byte), .condition_flags(condition_flags),
   .stack_pointer(stack_pointer), .busy(busy), .irq_pending(irq_pending),
   .irq_ack(irq_ack), .pop_data(pop_data), .pop_valid(pop_valid),
   .stk_addr(stk_addr), .stk_we(stk_we));

/* File: cfs_flag_unit.sv */
// flag update unit: computes the next condition flags from an operation result.
// assumes the datapath presents result, carry and half-carry in the same cycle as the kind.
module cfs_flag_unit (
   input wire logic [7:0] cc,
   input wire cfs_pkg::cfs_fl_t kind,
   input wire logic [7:0] result,
   input wire logic carry,
   input wire logic half,
   output logic [7:0] next_cc
);
   import cfs_pkg::*;

   // each class touches only its own flags; the mask is never changed here
   always_comb begin
      next_cc = cc | CC_FIXED_ONES;
      if (kind == FL_LOGIC || kind == FL_ADD || kind == FL_ARITH || kind == FL_SHIFT) begin
         next_cc[CC_N_BIT] = result[7];
         next_cc[CC_Z_BIT] = (result == 8'h00);
      end
      if (kind == FL_ADD || kind == FL_ARITH || kind == FL_SHIFT || kind == FL_BTJ) begin
         next_cc[CC_C_BIT] = carry;
      end
      if (kind == FL_ADD) begin
         next_cc[CC_H_BIT] = half;
      end
   end
endmodule

/* File: cfs_pkg.sv */
// package for the cpu flags and stack register block: field positions, reset values,
// operation codes and stack sequence lengths shared by the core and its helpers.
// assumes a single clock domain (mclk) and an asynchronous active-low reset.
// Operation
// - The program counter is 16 bits wide and holds the next instruction address as a low and a high byte.
// - The condition flags register is 8 bits, its top three bits always read one and it resets to 111x1xxx.
// - Add and add-with-carry set the half-carry flag on a carry from bit 3 into bit 4 and clear it otherwise.
// - Interrupt entry sets the mask flag, software may set or clear it, and a set mask blocks all but the trap.
// - A request arriving while masked is held pending and serviced once the mask is cleared.
// - Return from interrupt clears the mask, and a mask cleared inside a handler lets pending requests in.
// - After every arithmetic, logic or data operation the negative flag takes bit 7 of the result.
// - After every arithmetic, logic or data operation the zero flag shows whether the result is zero.
// - Carry shows overflow or underflow, has its own set and clear operations, and follows bit tests, shifts and rotates.
// - The 16-bit stack pointer addresses the next free byte, is decremented after a push and incremented before a pop.
// - The upper pointer bits are fixed for a 256-byte stack and reset or the stack reset operation loads 01FFh.
// - The pointer wraps silently from the lower limit to the upper limit and back on underflow.
// - Interrupt entry writes the program counter low byte first at the pointer and the other bytes below it.
// - A call uses exactly two stack bytes and an interrupt context save exactly five.
// - The low byte of the stack pointer can be read and loaded directly.
// - The automatic context save and restore never touch the second index register.
package cfs_pkg;
   // condition flag bit positions
   localparam int CC_H_BIT = 4;
   localparam int CC_I_BIT = 3;
   localparam int CC_N_BIT = 2;
   localparam int CC_Z_BIT = 1;
   localparam int CC_C_BIT = 0;
   localparam logic [7:0] CC_FIXED_ONES = 8'hE0;
   // unknown reset bits are chosen as zero
   localparam logic [7:0] CC_RESET = 8'hE8;
   localparam logic [7:0] SP_HIGH_FIXED = 8'h01;
   localparam logic [7:0] SP_LOW_RESET = 8'hFF;
   localparam logic [15:0] SP_RESET = 16'h01FF;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] RESULT_MSB = 8'h80;
   localparam logic [2:0] CALL_BYTES = 3'h2;
   localparam logic [2:0] INT_BYTES = 3'h5;
   // context byte indices in push order
   localparam logic [2:0] CTX_ADDR_LO = 3'h0;
   localparam logic [2:0] CTX_ADDR_HI = 3'h1;
   localparam logic [2:0] CTX_X = 3'h2;
   localparam logic [2:0] CTX_A = 3'h3;
   localparam logic [2:0] CTX_CC = 3'h4;

   typedef enum logic [3:0] {
      OP_NONE, OP_FLAGS, OP_SET_OVERFLOW, OP_CLEAR_OVERFLOW, OP_SIM, OP_UNMASK, OP_TRAP,
      OP_HANDLER_RETURN, OP_CALL, OP_RET, OP_STACK_RESET, OP_LD_S, OP_PUSH, OP_PUSH_CC,
      OP_POP, OP_POP_CC
   } cfs_op_t;

   // which flags an operation touches
   typedef enum logic [2:0] {
      FL_NONE, FL_LOGIC, FL_ADD, FL_ARITH, FL_SHIFT, FL_BTJ
   } cfs_fl_t;
endpackage

/* File: cfs_stack_ptr.sv */
// stack pointer unit: 256-byte stack with a fixed upper byte.
// assumes at most one of push, pop, rst_op, ld_low per cycle; priority resolves any overlap.
module cfs_stack_ptr (
   input wire logic mclk,
   input wire logic rst_n,
   cfs_stk_if.core stk
);
   import cfs_pkg::*;

   typedef struct packed {
      logic [7:0] low;
   } cfs_sp_state_t;

   cfs_sp_state_t s;
   cfs_sp_state_t next_s;

   // only the low byte moves; eight-bit arithmetic gives the silent wrap
   always_comb begin
      next_s = s;
      if (stk.rst_op) begin
         next_s.low = SP_LOW_RESET;
      end else if (stk.ld_low) begin
         next_s.low = stk.ld_data;
      end else if (stk.push) begin
         next_s.low = s.low - 8'h01;
      end else if (stk.pop) begin
         next_s.low = s.low + 8'h01;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{low: SP_LOW_RESET};
      end else begin
         s <= next_s;
      end
   end

   // pop reads one above the pointer since the pointer sits on the free byte
   assign stk.sp = {SP_HIGH_FIXED, s.low};
   assign stk.addr = stk.pop ? {SP_HIGH_FIXED, s.low + 8'h01} : {SP_HIGH_FIXED, s.low};
endmodule

/* File: cfs_stack_ram.sv */
// partner model: the stack ram that the register block reads and writes.
// assumes a combinational read port and a write on the rising mclk edge.
module cfs_stack_ram (
   input wire logic mclk,
   input wire logic [15:0] stk_addr,
   input wire logic stk_we,
   input wire logic [7:0] stk_wdata,
   output logic [7:0] stk_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [256];
   // unwritten bytes hold a marker so a stale read never looks like real data
   initial begin
      foreach (mem[i]) mem[i] = 8'hA5;
   end
   // the upper address byte is fixed, so only the low byte selects a cell
   always @(posedge mclk) begin
      if (stk_we) mem[stk_addr[7:0]] <= stk_wdata;
   end
   assign stk_rdata = mem[stk_addr[7:0]];
endmodule

/* File: cfs_stk_if.sv */
// interface between the register core and the stack pointer unit.
// assumes both ends run on mclk; all signals are plain levels sampled each cycle.
interface cfs_stk_if;
   logic push;
   logic pop;
   logic rst_op;
   logic ld_low;
   logic [7:0] ld_data;
   logic [15:0] sp;
   logic [15:0] addr;
   modport ctl (output push, output pop, output rst_op, output ld_low, output ld_data,
                input sp, input addr);
   modport core (input push, input pop, input rst_op, input ld_low, input ld_data,
                 output sp, output addr);
endinterface

/* File: tb.sv */
// self-checking bench for the cpu state registers with a stack ram partner.
// assumes inputs change on the falling edge and the ram answers combinationally.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cfs_pkg::*;
   typedef struct {cfs_op_t op; cfs_fl_t kind; logic [7:0] res; logic c; logic h;
      logic [7:0] exp;} cfs_row_t;
   logic mclk = 0, rst_n = 0, alu_carry = 0, alu_half = 0, jump_en = 0, pc_inc = 0;
   logic irq_req = 0, busy, irq_pending, stk_we, ctx_valid;
   cfs_op_t op = OP_NONE;
   cfs_fl_t fl_kind = FL_NONE;
   logic [7:0] alu_result = 0, push_data = 0, ld_s_data = 0, reg_a = 0, reg_x = 0;
   logic [7:0] stk_rdata, condition_flags, ctx_a, ctx_x, stk_wdata;
   logic [15:0] jump_addr = 0, int_vector = 0, program_counter, stack_pointer, stk_addr;
   int miscompares = 0, samples_checked = 0, cycles = 0;
   logic [7:0] ctx_exp [5] = '{8'h00, 8'h40, 8'hC3, 8'h3C, 8'hE5};
   cfs_row_t rows [11] = '{
      '{OP_FLAGS, FL_ADD, 8'h00, 1, 1, 8'hFB}, '{OP_FLAGS, FL_LOGIC, 8'h80, 0, 0, 8'hFD},
      '{OP_FLAGS, FL_ADD, 8'h7F, 0, 0, 8'hE8}, '{OP_FLAGS, FL_ARITH, 8'h00, 1, 1, 8'hEB},
      '{OP_FLAGS, FL_SHIFT, 8'hFF, 0, 1, 8'hEC}, '{OP_FLAGS, FL_BTJ, 8'h00, 1, 0, 8'hED},
      '{OP_FLAGS, FL_NONE, 8'h00, 0, 0, 8'hED},
      '{OP_CLEAR_OVERFLOW, FL_NONE, 8'h00, 0, 0, 8'hEC},
      '{OP_SET_OVERFLOW, FL_NONE, 8'h00, 0, 0, 8'hED},
      '{OP_UNMASK, FL_NONE, 8'h00, 0, 0, 8'hE5},
      '{OP_SIM, FL_NONE, 8'h00, 0, 0, 8'hED}};

   cfs_cpu_regs uut (.mclk(mclk), .rst_n(rst_n), .op(op), .fl_kind(fl_kind),
      .alu_result(alu_result), .alu_carry(alu_carry), .alu_half(alu_half),
      .push_data(push_data), .ld_s_data(ld_s_data), .jump_en(jump_en),
      .jump_addr(jump_addr), .pc_inc(pc_inc), .int_vector(int_vector), .irq_req(irq_req),
      .reg_a(reg_a), .reg_x(reg_x), .stk_rdata(stk_rdata),
      .program_counter(program_counter), .next_addr_low_byte(), .next_addr_high_byte(),
      .condition_flags(condition_flags), .stack_pointer(stack_pointer), .busy(busy),
      .irq_pending(irq_pending), .irq_ack(), .pop_data(), .pop_valid(), .ctx_a(ctx_a),
      .ctx_x(ctx_x), .ctx_valid(ctx_valid), .stk_addr(stk_addr), .stk_we(stk_we),
      .stk_wdata(stk_wdata));
   cfs_stack_ram ram (.mclk(mclk), .stk_addr(stk_addr), .stk_we(stk_we),
      .stk_wdata(stk_wdata), .stk_rdata(stk_rdata));

   always #5 mclk = ~mclk;
   // the whole run needs well under a hundred cycles, so this only trips on a hang
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         complete_run;
      end
   end

   task check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task done(input string name);
      $display("test %s finished, %0d mismatches so far", name, miscompares);
   endtask
   // issue one op, then wait (bounded) until any multi-cycle sequence ends
   task run(input cfs_op_t o);
      op = o;
      @(negedge mclk);
      op = OP_NONE;
      @(negedge mclk);
      for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge mclk);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (16) @(negedge mclk);
      rst_n = 1;
      check(program_counter, 16'h0000);
      check(condition_flags, 8'hE8);
      check(stack_pointer, 16'h01FF);
      done("reset");
      // table rows run back to back, each flag value checked a cycle later
      foreach (rows[i]) begin
         op = rows[i].op;
         fl_kind = rows[i].kind;
         alu_result = rows[i].res;
         alu_carry = rows[i].c;
         alu_half = rows[i].h;
         @(negedge mclk);
         check(condition_flags, rows[i].exp);
      end
      done("flag table");
      ld_s_data = 8'h00;
      run(OP_LD_S);
      check(stack_pointer, 16'h0100);
      push_data = 8'h5A;
      run(OP_PUSH);
      check(stack_pointer, 16'h01FF);
      check(ram.mem[8'h00], 8'h5A);
      run(OP_POP);
      check(stack_pointer, 16'h0100);
      run(OP_STACK_RESET);
      check(stack_pointer, 16'h01FF);
      done("stack wrap");
      jump_en = 1;
      jump_addr = 16'h1234;
      @(negedge mclk);
      jump_en = 0;
      jump_addr = 16'h4000;
      run(OP_CALL);
      check(program_counter, 16'h4000);
      check(stack_pointer, 16'h01FD);
      check({ram.mem[8'hFE], ram.mem[8'hFF]}, 16'h1234);
      done("call");
      // request while masked must wait, then enter once unmasked
      reg_a = 8'h3C;
      reg_x = 8'hC3;
      int_vector = 16'h8000;
      irq_req = 1;
      @(negedge mclk);
      irq_req = 0;
      repeat (2) @(negedge mclk);
      check(irq_pending, 1'b1);
      check(busy, 1'b0);
      run(OP_UNMASK);
      check(program_counter, 16'h8000);
      check(condition_flags, 8'hED);
      check(stack_pointer, 16'h01F8);
      for (int k = 0; k < 5; k++) check(ram.mem[8'hFD - k], ctx_exp[k]);
      done("interrupt entry");
      reg_a = 8'h00;
      reg_x = 8'h00;
      run(OP_HANDLER_RETURN);
      check(program_counter, 16'h4000);
      check(condition_flags, 8'hE5);
      check(stack_pointer, 16'h01FD);
      check({ctx_a, ctx_x}, 16'h3CC3);
      check(ctx_valid, 1'b1);
      done("interrupt return");
      // the call frame from earlier still sits above the pointer
      run(OP_RET);
      check(program_counter, 16'h1234);
      check(stack_pointer, 16'h01FF);
      pc_inc = 1;
      @(negedge mclk);
      pc_inc = 0;
      check(program_counter, 16'h1235);
      done("return");
      // the trap enters with the mask set
      run(OP_SIM);
      int_vector = 16'h9000;
      run(OP_TRAP);
      check(program_counter, 16'h9000);
      check(stack_pointer, 16'h01FA);
      check({ram.mem[8'hFE], ram.mem[8'hFF]}, 16'h1235);
      check(ram.mem[8'hFB], 8'hED);
      done("trap");
      // flags through the stack bring the carry back set after it is cleared
      run(OP_PUSH_CC);
      run(OP_CLEAR_OVERFLOW);
      check(condition_flags, 8'hEC);
      run(OP_POP_CC);
      check(condition_flags, 8'hED);
      check(stack_pointer, 16'h01FA);
      done("flags on stack");
      complete_run;
   end
endmodule
